/* regulator_pkg.sv */
// Constants for the sleep regulator power-mode controller
package regulator_pkg;
  // Register map, byte addresses
  localparam logic [7:0] CTRL_ADDR     = 8'h00;
  localparam logic [7:0] STATUS_ADDR   = 8'h04;
  localparam int         ADDR_W        = 8;
  // Regulator control layout
  localparam int         PM_BIT        = 1;
  localparam int         RSVD_BIT      = 0;
  localparam logic       PM_RESET      = 1'b0;
  localparam logic       RSVD_RESET    = 1'b1;
  // Status register layout
  localparam int         ST_SLEEP_BIT  = 0;
  localparam int         ST_LP_BIT     = 1;
  localparam int         ST_WAKE_BIT   = 2;
  localparam int         ST_CHG_BIT    = 3;
  localparam int         ST_CAP_BIT    = 4;
  // Timing
  localparam int         CLK_HZ        = 10_000_000;
  localparam int         STAB_NS       = 10_000;
  localparam int         STAB_CYC      = (STAB_NS * (CLK_HZ / 1_000_000)
                                          + 999) / 1000;
  localparam int         CHARGE_US     = 1_000;
  localparam int         CHARGE_CYC    = CHARGE_US * (CLK_HZ / 1_000_000);
  localparam int         SYNC_STAGES   = 3;
  // Peripheral enable vector: width and low-power mask
  localparam int         NPERIPH       = 8;
  localparam logic [7:0] LP_OK_MASK    = 8'h1f;
endpackage

/* pin_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
  import regulator_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sh;
    logic                   q;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.sh = {st_r.sh[SYNC_STAGES-2:0], d_i};
    if (st_r.sh[1] == st_r.sh[2]) begin
      st_nxt.q = st_r.sh[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{sh: {SYNC_STAGES{INIT}}, q: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;
endmodule

/* sleep_regulator_power_mode.sv */
// Sleep regulator power-mode controller with Wishbone registers
// Contract
// - Low-power select clear keeps regulator normal in sleep, no extra delay.
// - Waking from low-power sleep inserts a stabilisation delay first.
// - Incompatible active peripherals force normal regulator state in sleep.
// - Low-power allowed with only BOR, WDT, pin interrupts, ext timer, capture.
// - Power-mode bit 1, read/write, resets zero; one selects low power.
// - Bit 0 reserved, resets and reads one; bits 7..2 read zero.
// - Variant without regulator has no select, lowest power, no wake delay.
// - Regulator always active; no software enable or disable.
// - Configuration bit picks capacitor pin; zero means port A bit 5.
// - Hold reset at power-up until regulator capacitor is charged; code also releases reset after CHARGE_CYCLES cycles without it.
// - Power-down only on sleep instruction; selection applies for that sleep.
`timescale 1ns/1ps
module sleep_regulator_power_mode
  import regulator_pkg::*;
#(
  parameter bit HAS_REGULATOR = 1'b1,
  parameter int STAB_CYCLES   = STAB_CYC,
  parameter int CHARGE_CYCLES = CHARGE_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Sleep sequencing
  input  wire logic              sleep_exec_i,
  input  wire logic              wake_event_i,
  input  wire logic [NPERIPH-1:0] periph_active_i,
  input  wire logic              cap_pin_select_i,
  input  wire logic              cap_charged_i,
  output logic                   core_reset_o,
  output logic                   cap_charge_en_o,
  output logic                   port_a_bit5_pin_cap_o,
  output logic                   alt_cap_pin_o,
  output logic                   regulator_enable_o,
  output logic                   regulator_low_power_o,
  output logic                   sleeping_o,
  output logic                   resume_o
);
  localparam int CW = $clog2(CHARGE_CYCLES + 1) > $clog2(STAB_CYCLES + 1)
                    ? $clog2(CHARGE_CYCLES + 1) : $clog2(STAB_CYCLES + 1);
  localparam logic [CW-1:0] STAB_LAST   = CW'(STAB_CYCLES - 1);
  localparam logic [CW-1:0] CHARGE_LAST = CW'(CHARGE_CYCLES - 1);

  typedef enum logic [2:0] {
    S_CHARGE,
    S_AWAKE,
    S_SLEEP,
    S_STAB,
    S_RESUME
  } state_e;

  typedef struct packed {
    state_e        st;
    logic [CW-1:0] cnt;
    logic          pm;
    logic          lp_taken;
    logic          lp_now;
    logic          cap_sel;
    logic          charged_once;
    logic          ack;
    logic [31:0]   dat;
    logic          core_rst;
    logic          charge_en;
    logic          sleeping;
    logic          resume;
  } ctrl_s;

  ctrl_s ctrl_r;
  ctrl_s ctrl_nxt;

  logic cap_sync;
  logic lp_allowed;
  logic wb_req;

  // ----------------------------------------------------------------
  // Pin synchroniser for the capacitor charge comparator
  // ----------------------------------------------------------------
  pin_sync #(
    .INIT (1'b0)
  ) u_cap_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cap_charged_i),
    .q_o   (cap_sync)
  );

  // Only the listed sleep-friendly peripherals may run in low power
  assign lp_allowed = ((periph_active_i & ~LP_OK_MASK) == '0);
  assign wb_req     = cyc_i & stb_i & ~ctrl_r.ack;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt        = ctrl_r;
    ctrl_nxt.ack    = 1'b0;
    ctrl_nxt.resume = 1'b0;

    // Register access, one wait state
    if (wb_req) begin
      ctrl_nxt.ack = 1'b1;
      ctrl_nxt.dat = '0;
      if (we_i) begin
        if (adr_i == CTRL_ADDR && sel_i[0] && HAS_REGULATOR) begin
          ctrl_nxt.pm = dat_i[PM_BIT];
        end
      end else begin
        case (adr_i)
          CTRL_ADDR: begin
            ctrl_nxt.dat[PM_BIT]   = ctrl_r.pm;
            ctrl_nxt.dat[RSVD_BIT] = RSVD_RESET;
          end
          STATUS_ADDR: begin
            ctrl_nxt.dat[ST_SLEEP_BIT] = ctrl_r.sleeping;
            ctrl_nxt.dat[ST_LP_BIT]    = ctrl_r.lp_now;
            ctrl_nxt.dat[ST_WAKE_BIT]  = (ctrl_r.st == S_STAB);
            ctrl_nxt.dat[ST_CHG_BIT]   = ctrl_r.charge_en;
            ctrl_nxt.dat[ST_CAP_BIT]   = ctrl_r.cap_sel;
          end
          default: begin
            ctrl_nxt.dat = '0;
          end
        endcase
      end
    end

    case (ctrl_r.st)
      S_CHARGE: begin
        // Core held in reset while the capacitor charges
        ctrl_nxt.core_rst  = 1'b1;
        ctrl_nxt.charge_en = 1'b1;
        if (!ctrl_r.charged_once) begin
          ctrl_nxt.cap_sel      = cap_pin_select_i;
          ctrl_nxt.charged_once = 1'b1;
        end
        if (ctrl_r.cnt != CHARGE_LAST) begin
          ctrl_nxt.cnt = ctrl_r.cnt + CW'(1);
        end
        if (cap_sync || ctrl_r.cnt == CHARGE_LAST) begin
          ctrl_nxt.st        = S_AWAKE;
          ctrl_nxt.core_rst  = 1'b0;
          ctrl_nxt.charge_en = 1'b0;
          ctrl_nxt.cnt       = '0;
        end
      end
      S_AWAKE: begin
        if (sleep_exec_i && !wake_event_i) begin
          ctrl_nxt.st       = S_SLEEP;
          ctrl_nxt.sleeping = 1'b1;
          ctrl_nxt.lp_taken = ctrl_r.pm & HAS_REGULATOR;
        end
      end
      S_SLEEP: begin
        ctrl_nxt.lp_now = ctrl_r.lp_taken & lp_allowed;
        if (wake_event_i) begin
          ctrl_nxt.lp_now = 1'b0;
          if (ctrl_r.lp_now) begin
            ctrl_nxt.st  = S_STAB;
            ctrl_nxt.cnt = '0;
          end else begin
            ctrl_nxt.st       = S_RESUME;
            ctrl_nxt.sleeping = 1'b0;
            ctrl_nxt.resume   = 1'b1;
          end
        end
      end
      S_STAB: begin
        ctrl_nxt.cnt = ctrl_r.cnt + CW'(1);
        if (ctrl_r.cnt == STAB_LAST) begin
          ctrl_nxt.st       = S_RESUME;
          ctrl_nxt.sleeping = 1'b0;
          ctrl_nxt.resume   = 1'b1;
          ctrl_nxt.cnt      = '0;
        end
      end
      S_RESUME: begin
        ctrl_nxt.st = S_AWAKE;
      end
      default: begin
        ctrl_nxt.st = S_AWAKE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '{st: S_CHARGE, cnt: '0, pm: PM_RESET, lp_taken: 1'b0,
                  lp_now: 1'b0, cap_sel: 1'b0, charged_once: 1'b0,
                  ack: 1'b0, dat: '0, core_rst: 1'b1, charge_en: 1'b1,
                  sleeping: 1'b0, resume: 1'b0};
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o                 = ctrl_r.dat;
  assign ack_o                 = ctrl_r.ack;
  assign core_reset_o          = ctrl_r.core_rst;
  assign cap_charge_en_o       = ctrl_r.charge_en;
  assign port_a_bit5_pin_cap_o = ~ctrl_r.cap_sel;
  assign alt_cap_pin_o         = ctrl_r.cap_sel;
  assign regulator_enable_o    = HAS_REGULATOR;
  assign regulator_low_power_o = ctrl_r.lp_now;
  assign sleeping_o            = ctrl_r.sleeping;
  assign resume_o              = ctrl_r.resume;
endmodule

/* sleep_regulator_power_mode_monitor.sv */
// Checker for the sleep regulator power-mode controller
`timescale 1ns/1ps
module sleep_regulator_power_mode_monitor
  import regulator_pkg::*;
#(
  parameter int STAB_CYCLES = 8
) (
  input wire logic               clk_i, rst_i, cyc_i, stb_i, ack_o,
  input wire logic               sleep_exec_i, wake_event_i, core_reset_o,
  input wire logic [NPERIPH-1:0] periph_active_i,
  input wire logic               cap_pin_select_i, port_a_bit5_pin_cap_o,
  input wire logic               alt_cap_pin_o, regulator_enable_o,
  input wire logic               regulator_low_power_o, sleeping_o, resume_o
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_always_on: assert property (regulator_enable_o)
    else $error("regulator not enabled");
  chk_cap_pin_map: assert property (!core_reset_o && !$past(core_reset_o)
    |-> $stable(port_a_bit5_pin_cap_o))
    else $error("capacitor pin changed after power-up");
  chk_cap_pin_pair: assert property (alt_cap_pin_o != port_a_bit5_pin_cap_o)
    else $error("both or neither capacitor pin chosen");
  chk_sleep_entry: assert property (sleep_exec_i && !wake_event_i
    && !sleeping_o && !core_reset_o && !resume_o |=> sleeping_o)
    else $error("sleep not entered");
  chk_lp_in_sleep: assert property (regulator_low_power_o |-> sleeping_o)
    else $error("low power while awake");
  chk_incompat_normal: assert property (|(periph_active_i & ~LP_OK_MASK)
    && $past(|(periph_active_i & ~LP_OK_MASK)) |-> !regulator_low_power_o)
    else $error("low power with incompatible peripheral");
  chk_lp_wake_delay: assert property (sleeping_o && regulator_low_power_o
    && wake_event_i |=> !resume_o [*4])
    else $error("low-power wake without settling delay");
endmodule
bind sleep_regulator_power_mode sleep_regulator_power_mode_monitor
  #(.STAB_CYCLES(STAB_CYCLES)) i_mon (.*);

/* tb_sleep_regulator_power_mode.sv */
// Self-checking bench for the sleep regulator power-mode controller
`timescale 1ns/1ps
module tb_sleep_regulator_power_mode;
  import regulator_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 8'h00, periph_active_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, sleep_exec_i = 0, wake_event_i = 0, cap_charged_i = 0;
  logic        cap_pin_select_i = 0, core_reset_o, cap_charge_en_o;
  logic        port_a_bit5_pin_cap_o, alt_cap_pin_o, regulator_enable_o;
  logic        regulator_low_power_o, sleeping_o, resume_o;
  int          n_fail = 0, tests_run = 0, n;
  always #50 clk_i = ~clk_i;
  sleep_regulator_power_mode #(.STAB_CYCLES(8), .CHARGE_CYCLES(2000))
    i_dut (.*);
  // -----
  // Tasks
  // -----
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_hi(ref logic s);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (s !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_fail++;
      wrap_up;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    wait_hi(ack_o);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic nap(input logic [7:0] per, input logic [31:0] mode, mid,
                     input logic lp, input int stab);
    wb(1, CTRL_ADDR, mode);
    periph_active_i <= per;
    sleep_exec_i <= 1;
    @(posedge clk_i);
    sleep_exec_i <= 0;
    wb(1, CTRL_ADDR, mid);
    check("low_power", regulator_low_power_o, lp);
    check("sleeping", sleeping_o, 1);
    wake_event_i <= 1;
    wait_hi(resume_o);
    wake_event_i <= 0;
    check("wake_cycles", n, 2 + stab);
    $display("sleep test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    check("reset_hold", core_reset_o, 1);
    wb(0, CTRL_ADDR, 0);
    check("ctrl_reset", q, 32'h1);
    wb(1, CTRL_ADDR, 32'hff);
    wb(0, CTRL_ADDR, 0);
    check("ctrl_all", q, 32'h3);
    wb(1, CTRL_ADDR, 32'h0);
    wb(0, CTRL_ADDR, 0);
    check("ctrl_rsvd", q, 32'h1);
    wb(1, 8'h08, 32'hff);
    wb(0, 8'h08, 0);
    check("unmapped", q, 32'h0);
    sleep_exec_i <= 1;
    @(posedge clk_i);
    sleep_exec_i <= 0;
    repeat (2) @(posedge clk_i);
    check("sleep_charging", sleeping_o, 0);
    cap_charged_i <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (core_reset_o !== 1'b0 && n < 20);
    check("charge_release", n < 20, 1);
    if (n >= 20) wrap_up;
    $display("register and charge test done");
    check("cap_pin", port_a_bit5_pin_cap_o, 1);
    check("charge_off0", cap_charge_en_o, 0);
    cap_pin_select_i <= 1;
    repeat (3) @(posedge clk_i);
    check("cap_pin_held", alt_cap_pin_o, 0);
    check("always_on", regulator_enable_o, 1);
    nap(8'h1f, 32'h3, 32'h1, 1, 8);
    nap(8'h1f, 32'h1, 32'h1, 0, 0);
    nap(8'h20, 32'h3, 32'h3, 0, 0);
    nap(8'h80, 32'h3, 32'h1, 0, 0);
    wb(1, CTRL_ADDR, 32'h3);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    check("rst_hold", core_reset_o, 1);
    check("rst_charge", cap_charge_en_o, 1);
    wb(0, CTRL_ADDR, 0);
    check("ctrl_rerst", q, 32'h1);
    repeat (8) @(posedge clk_i);
    check("charge_off", cap_charge_en_o, 0);
    check("alt_pin", alt_cap_pin_o, 1);
    check("porta_pin", port_a_bit5_pin_cap_o, 0);
    $display("second reset test done");
    wrap_up;
  end
endmodule
